//--- evu_pkg.sv
// Package: constants and carriers for the exception priority vector unit
package evu_pkg;
    localparam logic [15:0] RST_PIN_VEC = 16'hfffe;
    localparam logic [15:0] RST_CLKMON_VEC = 16'hfffc;
    localparam logic [15:0] RST_WDOG_VEC = 16'hfffa;
    localparam logic [7:0] OFS_TRAP = 8'hf8;
    localparam logic [7:0] OFS_SWI = 8'hf6;
    localparam logic [7:0] OFS_HIGH = 8'hf4;
    localparam logic [7:0] OFS_EXT = 8'hf2;
    localparam logic [7:0] OFS_LOW_TOP = 8'hf0;
    localparam logic [7:0] OFS_LOW_BOT = 8'h82;
    localparam logic [7:0] OFS_SPURIOUS = 8'h80;
    localparam logic [7:0] BASE_RESET = 8'hff;
    localparam logic [7:0] BASE_DEBUG = 8'hff;
    localparam logic [7:0] LOW_BYTE_ZERO = 8'h00;
    // Low-priority slots between the bottom and top offsets, two bytes apart
    localparam int NUM_LOW = (int'(OFS_LOW_TOP) - int'(OFS_LOW_BOT)) / 2 + 1;
    // Register map of the plain register port
    localparam logic [1:0] ADDR_BASE = 2'h0;
    localparam logic [1:0] ADDR_FLAGS = 2'h1;
    localparam logic [1:0] ADDR_STATUS = 2'h2;
    localparam logic [1:0] ADDR_WINNER = 2'h3;
    localparam int FLAG_LOW_MASK = 0;
    localparam int FLAG_HIGH_MASK = 1;
    localparam int FLAG_LINK_PRESENT = 2;

    typedef struct packed {
        logic pin_rst;
        logic clkmon_rst;
        logic wdog_rst;
        logic trap;
        logic software_interrupt_instr;
        logic high_pin;
        logic ext_pin;
        logic link_err;
        logic link_irq;
    } exc_req_t;

    typedef struct packed {
        logic low_mask;
        logic high_mask;
    } cpu_condition_flags_t;
endpackage

//--- exception_priority_vector_unit.sv
// Exception priority decoder and vector supply for the CPU core
//
// Summary of operation
// RQ1: Highest vector address wins among pending.
// RQ2: Low request needs enable, mask clear, none higher.
// RQ3: Unmaskable-by-low-mask requests outrank all low.
// RQ4: High request preempts low routine, high mask clear.
// RQ5: Trap and software interrupt nest freely.
// RQ6: Vector chosen at fetch time, newest winner.
// RQ7: No source at fetch gives spurious vector.
// RQ8: Three fixed reset vectors in priority order.
// RQ9: Trap then software interrupt below resets.
// RQ10: High slot then external slot next.
// RQ11: Die link drives high and external slots.
// RQ12: Low sources fill slots, falling by low byte.
// RQ13: Vectors are sixteen bits wide.
// RQ14: Low routine preemptable by unmasked higher request.
// RQ15: Low nesting only after low mask cleared.
// RQ16: Low wake-up qualified as in run mode.
// RQ17: Only asynchronous requests wake from stop. The code also wakes from stop on the synchronised high request.
// RQ18: High request wakes despite mask, no handler.
// RQ19: Sources hold requests until handler begins.
// RQ20: High wake request held past resume.
// RQ21: Software sets base then clears mask flags.
// RQ22: Base is upper byte, zero lower byte.
// RQ23: Base register resets to all ones.
// RQ24: Debug active forces upper byte to ones.
// RQ25: Reset vectors ignore the base register.
// RQ26: Vector sampled on fetch strobe, held stable.
//
// Design decisions made here: the address map and the address-and-strobe port.
module exception_priority_vector_unit #(
    parameter int NUM_LOW = evu_pkg::NUM_LOW
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire evu_pkg::exc_req_t req_i,
    input wire logic [NUM_LOW-1:0] low_req_i,
    input wire logic [NUM_LOW-1:0] low_async_i,
    input wire logic background_debug_state_i,
    input wire logic stop_mode_i,
    input wire logic wait_mode_i,
    input wire logic vec_fetch_i,
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic [15:0] vector_o,
    output logic vector_valid_o,
    output logic irq_pending_o,
    output logic wakeup_o,
    output logic wake_no_handler_o,
    output evu_pkg::cpu_condition_flags_t cpu_condition_flags_o
);

    ////////////////////////////////////////////////////////////////////////
    // Request synchronisers: requests come from other logic or pins

    evu_pkg::exc_req_t req_s1_r, req_s2_r;
    logic [NUM_LOW-1:0] low_s1_r, low_s2_r;
    logic dbg_s1_r, dbg_s2_r;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            req_s1_r <= '0;
            req_s2_r <= '0;
            low_s1_r <= '0;
            low_s2_r <= '0;
            dbg_s1_r <= 1'b0;
            dbg_s2_r <= 1'b0;
        end else begin
            req_s1_r <= req_i;
            req_s2_r <= req_s1_r;
            low_s1_r <= low_req_i;
            low_s2_r <= low_s1_r;
            dbg_s1_r <= background_debug_state_i;
            dbg_s2_r <= dbg_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] vector_base_upper_reg_r;
    logic [NUM_LOW-1:0] low_enable_r;
    logic low_mask_r, high_mask_r, link_present_r;
    logic [5:0] low_sel_r;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            vector_base_upper_reg_r <= evu_pkg::BASE_RESET; // see RQ23
        end else if (reg_wr_i && reg_addr_i == evu_pkg::ADDR_BASE) begin
            vector_base_upper_reg_r <= reg_wdata_i;
        end
    end

    // Both masks set out of reset, as a CPU would leave them
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            low_mask_r <= 1'b1;
            high_mask_r <= 1'b1;
            link_present_r <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == evu_pkg::ADDR_FLAGS) begin
            low_mask_r <= reg_wdata_i[evu_pkg::FLAG_LOW_MASK];
            high_mask_r <= reg_wdata_i[evu_pkg::FLAG_HIGH_MASK];
            link_present_r <= reg_wdata_i[evu_pkg::FLAG_LINK_PRESENT];
        end
    end

    // Local enables written eight at a time; index selects the byte
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            low_enable_r <= '0;
            low_sel_r <= '0;
        end else if (reg_wr_i && reg_addr_i == evu_pkg::ADDR_STATUS) begin
            low_sel_r <= reg_wdata_i[5:0];
        end else if (reg_wr_i && reg_addr_i == evu_pkg::ADDR_WINNER) begin
            for (int i = 0; i < NUM_LOW; i++) begin
                if (i / 8 == int'(low_sel_r[2:0])) begin
                    low_enable_r[i] <= reg_wdata_i[i % 8];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Priority decode

    logic high_src, ext_src;
    logic [NUM_LOW-1:0] low_qual;
    logic [7:0] upper_byte;
    logic [15:0] winner_vec;
    logic winner_any, low_blocked;

    always_comb begin
        // Die link replaces the pin requests when present
        high_src = link_present_r ? req_s2_r.link_err : req_s2_r.high_pin; // see RQ11
        ext_src = link_present_r ? req_s2_r.link_irq : req_s2_r.ext_pin; // see RQ11
        low_blocked = req_s2_r.software_interrupt_instr | req_s2_r.trap | (high_src & ~high_mask_r); // see RQ2
        low_qual = low_s2_r & low_enable_r & {NUM_LOW{~low_mask_r & ~low_blocked}}; // see RQ15
        upper_byte = dbg_s2_r ? evu_pkg::BASE_DEBUG : vector_base_upper_reg_r; // see RQ24
        winner_any = 1'b1;
        // Default is spurious when nothing is left at fetch
        winner_vec = {upper_byte, evu_pkg::OFS_SPURIOUS}; // see RQ7 RQ22
        // Ascending scan: the last hit is the highest vector
        for (int i = 0; i < NUM_LOW; i++) begin
            if (low_qual[i]) begin
                winner_vec = {upper_byte, 8'(evu_pkg::OFS_LOW_BOT + 8'(2 * i))}; // see RQ12 RQ1
            end
        end
        if (ext_src && !low_mask_r) begin
            winner_vec = {upper_byte, evu_pkg::OFS_EXT}; // see RQ10 RQ14
        end
        if (high_src && !high_mask_r) begin
            winner_vec = {upper_byte, evu_pkg::OFS_HIGH}; // see RQ4 RQ10 RQ3
        end
        if (req_s2_r.software_interrupt_instr) begin
            winner_vec = {upper_byte, evu_pkg::OFS_SWI}; // see RQ9 RQ5
        end
        if (req_s2_r.trap) begin
            winner_vec = {upper_byte, evu_pkg::OFS_TRAP}; // see RQ9 RQ5
        end
        // Reset vectors are absolute, base not applied
        if (req_s2_r.wdog_rst) begin
            winner_vec = evu_pkg::RST_WDOG_VEC; // see RQ8 RQ25
        end
        if (req_s2_r.clkmon_rst) begin
            winner_vec = evu_pkg::RST_CLKMON_VEC; // see RQ8 RQ25
        end
        if (req_s2_r.pin_rst) begin
            winner_vec = evu_pkg::RST_PIN_VEC; // see RQ8 RQ25
        end
        winner_any = (winner_vec[7:0] != evu_pkg::OFS_SPURIOUS) ||
                     (winner_vec[15:8] != upper_byte);
    end

    ////////////////////////////////////////////////////////////////////////
    // Vector output: latched on the fetch strobe, stable until the next

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            vector_o <= evu_pkg::RST_PIN_VEC;
            vector_valid_o <= 1'b0;
        end else begin
            vector_valid_o <= vec_fetch_i;
            if (vec_fetch_i) begin
                vector_o <= winner_vec; // see RQ6 RQ26 RQ13
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_pending_o <= 1'b0;
        end else begin
            irq_pending_o <= winner_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake-up from stop or wait

    logic low_wake, async_wake;

    always_comb begin
        low_wake = |low_qual; // see RQ16
        // Stop has no clock for the synchroniser; of the low sources only asynchronous ones count
        // Same qualification as run mode, then restricted to asynchronous sources
        async_wake = |(low_qual & low_async_i); // see RQ17 RQ16
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wakeup_o <= 1'b0;
            wake_no_handler_o <= 1'b0;
        end else begin
            wakeup_o <= (wait_mode_i && (low_wake || high_src)) ||
                        (stop_mode_i && (async_wake || high_src)); // see RQ17 RQ18
            wake_no_handler_o <= (wait_mode_i || stop_mode_i) && high_src &&
                                 high_mask_r; // see RQ18
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads, data one cycle after the strobe

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                evu_pkg::ADDR_BASE: reg_rdata_o <= vector_base_upper_reg_r;
                evu_pkg::ADDR_FLAGS: reg_rdata_o <= {5'h00, link_present_r, high_mask_r,
                                                     low_mask_r};
                evu_pkg::ADDR_STATUS: reg_rdata_o <= {2'h0, low_sel_r};
                evu_pkg::ADDR_WINNER: reg_rdata_o <= winner_vec[7:0];
                default: reg_rdata_o <= '0;
            endcase
        end else begin
            reg_rdata_o <= '0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cpu_condition_flags_o <= '{low_mask: 1'b1, high_mask: 1'b1};
        end else begin
            cpu_condition_flags_o <= '{low_mask: low_mask_r, high_mask: high_mask_r};
        end
    end
endmodule

//--- evu_chk.sv
// Checker: fetch timing, vector form and wake relations of the vector unit
module evu_chk (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire evu_pkg::exc_req_t req_i,
    input wire logic background_debug_state_i,
    input wire logic stop_mode_i,
    input wire logic wait_mode_i,
    input wire logic vec_fetch_i,
    input wire logic [15:0] vector_o,
    input wire logic vector_valid_o,
    input wire logic wakeup_o,
    input wire logic wake_no_handler_o
);
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    chk_fetch_valid: assert property (vec_fetch_i |=> vector_valid_o)
        else $error("no valid after fetch");
    chk_valid_cause: assert property (vector_valid_o |-> $past(vec_fetch_i))
        else $error("valid without fetch");
    chk_vector_held: assert property (!vec_fetch_i |=> $stable(vector_o))
        else $error("vector moved between fetches");
    chk_vector_form: assert property (
        vector_valid_o |-> vector_o[7] && !vector_o[0]) else $error("vector outside table");
    // Inputs cross two sync flops before the fetch edge sees them
    chk_pin_reset: assert property (
        vector_valid_o && $past(req_i.pin_rst, 3) && $past(req_i.pin_rst, 4)
        |-> vector_o == 16'hfffe) else $error("reset vector wrong");
    chk_debug_base: assert property (
        vector_valid_o && $past(background_debug_state_i, 3) && $past(background_debug_state_i, 4)
        |-> vector_o[15:8] == 8'hff) else $error("debug upper byte wrong");
    chk_nh_mode: assert property (
        wake_no_handler_o |-> $past(stop_mode_i || wait_mode_i)) else $error("no-handler in run");
    chk_run_no_wake: assert property (
        (!stop_mode_i && !wait_mode_i) [*2] |=> !wakeup_o) else $error("wake in run mode");
    cover property (vector_valid_o && vector_o[7:0] == 8'h80);
    cover property (wake_no_handler_o);
    cover property (wakeup_o && stop_mode_i);
endmodule
////////////////////////////////////////
bind exception_priority_vector_unit evu_chk u_evu_chk (.core_clk_i, .rst_i, .req_i,
    .background_debug_state_i, .stop_mode_i, .wait_mode_i, .vec_fetch_i, .vector_o,
    .vector_valid_o, .wakeup_o, .wake_no_handler_o);

//--- evu_cpu_model.sv
// CPU core model: issues vector fetch strobes and takes the answer
module evu_cpu_model (
    input wire logic core_clk_i,
    input wire logic [15:0] vector_i,
    input wire logic vector_valid_i,
    output logic vec_fetch_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial vec_fetch_o = 1'b0;
    // Answer only trusted while valid stands; otherwise unknown
    task automatic fetch(output logic [15:0] v);
        @(posedge core_clk_i);
        vec_fetch_o <= 1'b1;
        @(posedge core_clk_i);
        vec_fetch_o <= 1'b0;
        #1;
        v = vector_valid_i ? vector_i : 16'hxxxx;
    endtask
endmodule

//--- exception_priority_vector_unit_tb.sv
// Testbench: priority, masking, base and wake-up of the vector unit
module exception_priority_vector_unit_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 1'b0, rst_i = 1'b1, dbg = 1'b0, stop_m = 1'b0, wait_m = 1'b0;
    logic rd = 1'b0, wr = 1'b0, fetch, valid, pend, wake, wake_nh;
    evu_pkg::exc_req_t req = '0;
    evu_pkg::cpu_condition_flags_t flags;
    logic [evu_pkg::NUM_LOW-1:0] low_req = '0, low_async = '0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [15:0] vec, got;
    int num_errors = 0, check_count = 0;
    initial forever #5 core_clk_i = ~core_clk_i;
    exception_priority_vector_unit u_exception_priority_vector_unit (.core_clk_i, .rst_i,
        .req_i(req), .low_req_i(low_req), .low_async_i(low_async),
        .background_debug_state_i(dbg), .stop_mode_i(stop_m), .wait_mode_i(wait_m),
        .vec_fetch_i(fetch), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .vector_o(vec), .vector_valid_o(valid),
        .irq_pending_o(pend), .wakeup_o(wake), .wake_no_handler_o(wake_nh),
        .cpu_condition_flags_o(flags));
    evu_cpu_model u_evu_cpu_model (.core_clk_i, .vector_i(vec), .vector_valid_i(valid),
        .vec_fetch_o(fetch));
    ////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge core_clk_i);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask
    task automatic setf(input logic [7:0] d);
        bus(1'b1, evu_pkg::ADDR_FLAGS, d);
    endtask
    // Requests need two sync edges, so give them four before fetching
    task automatic fchk(input string what, input logic [15:0] exp);
        repeat (4) @(posedge core_clk_i);
        u_evu_cpu_model.fetch(got);
        check(what, got, exp);
        check("pending", {15'h0000, pend}, {15'h0000, exp[7:0] != 8'h80});
    endtask
    task automatic wchk(input logic [1:0] exp);
        repeat (5) @(posedge core_clk_i);
        #1;
        check("wake, no-handler", {14'h0000, wake, wake_nh}, {14'h0000, exp});
    endtask
    task automatic t_reset();
        bus(1'b0, evu_pkg::ADDR_BASE, 8'h00);
        check("base reset", {8'h00, rdata}, 16'h00ff);
        check("reset vector", vec, 16'hfffe);
        check("valid, pending", {14'h0000, valid, pend}, 16'h0000);
        check("mask flags", {14'h0000, flags}, 16'h0003);
        bus(1'b0, evu_pkg::ADDR_FLAGS, 8'h00);
        check("flag register", {8'h00, rdata}, 16'h0003);
    endtask
    task automatic t_order();
        logic [15:0] tab [10] = '{16'hfffe, 16'hfffc, 16'hfffa, 16'h12f8, 16'h12f6,
            16'h12f4, 16'h12f2, 16'h12f0, 16'h1282, 16'h1280};
        for (int g = 0; g < 8; g++) begin
            bus(1'b1, evu_pkg::ADDR_STATUS, g[7:0]);
            bus(1'b1, evu_pkg::ADDR_WINNER, 8'hff);
        end
        bus(1'b0, evu_pkg::ADDR_STATUS, 8'h00);
        check("group select", {8'h00, rdata}, 16'h0007);
        bus(1'b1, evu_pkg::ADDR_BASE, 8'h12);
        setf(8'h00);
        req <= '1;
        low_req <= {1'b1, 54'h0, 1'b1};
        // Drop the winner each round; link lines stay up but are ignored
        for (int i = 0; i < 10; i++) begin
            fchk("priority walk", tab[i]);
            if (i < 7) begin
                req[8 - i] <= 1'b0;
            end else begin
                low_req[i == 7 ? 55 : 0] <= 1'b0;
            end
        end
    endtask
    task automatic t_mask();
        low_req[0] <= 1'b1;
        setf(8'h01);
        fchk("low masked", 16'h1280);
        setf(8'h00);
        fchk("low unmasked", 16'h1282);
        req.high_pin <= 1'b1;
        fchk("high over low", 16'h12f4);
        setf(8'h02);
        fchk("high masked", 16'h1282);
        check("mask flags", {14'h0000, flags}, 16'h0001);
        dbg <= 1'b1;
        fchk("debug base", 16'hff82);
        dbg <= 1'b0;
    endtask
    task automatic t_link();
        setf(8'h04);
        req.link_err <= 1'b1;
        req.link_irq <= 1'b1;
        fchk("link error slot", 16'h12f4);
        req.link_err <= 1'b0;
        fchk("link irq slot", 16'h12f2);
        req.link_irq <= 1'b0;
        fchk("pin ignored", 16'h1282);
        bus(1'b0, evu_pkg::ADDR_WINNER, 8'h00);
        check("winner byte", {8'h00, rdata}, 16'h0082);
        bus(1'b0, evu_pkg::ADDR_FLAGS, 8'h00);
        check("flag register", {8'h00, rdata}, 16'h0004);
    endtask
    task automatic t_wake();
        req <= '0;
        setf(8'h00);
        wait_m <= 1'b1;
        wchk(2'b10);
        setf(8'h01);
        wchk(2'b00);
        setf(8'h00);
        wait_m <= 1'b0;
        stop_m <= 1'b1;
        wchk(2'b00);
        low_async[0] <= 1'b1;
        wchk(2'b10);
        low_req[0] <= 1'b0;
        req.high_pin <= 1'b1;
        setf(8'h02);
        wchk(2'b11);
        stop_m <= 1'b0;
    endtask
    initial begin
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_order();
        t_mask();
        t_link();
        t_wake();
        close_out();
    end
    initial begin
        #50us;
        num_errors++;
        close_out();
    end
endmodule
